// ### rtl/clsm_pkg.sv
// constants shared by the converter lane sample mapper
// assumes a single frame clock; one frame of samples in, one frame of lane words out
`default_nettype none

package clsm_pkg;
   localparam int CLSM_CHANNELS = 4;
   localparam int CLSM_SAMPLES = 8;
   localparam int CLSM_SAMPLE_BITS = 9;
   localparam int CLSM_LANES = 8;
   localparam int CLSM_LANE_BITS = 40;
   localparam int CLSM_SMP_W = CLSM_CHANNELS * CLSM_SAMPLES * CLSM_SAMPLE_BITS;
   localparam int CLSM_MAP_W = CLSM_LANES * CLSM_LANE_BITS;
   localparam int CLSM_REC_W = CLSM_MAP_W + CLSM_LANES + 3 + 1;

   localparam logic [3:0] CLSM_MODE_4 = 4'h4;
   localparam logic [3:0] CLSM_MODE_5 = 4'h5;
   localparam logic [3:0] CLSM_MODE_6 = 4'h6;
   localparam logic [3:0] CLSM_MODE_7 = 4'h7;
   localparam logic [3:0] CLSM_MODE_8 = 4'h8;
   localparam logic [3:0] CLSM_MODE_9 = 4'h9;
   localparam logic [3:0] CLSM_MODE_10 = 4'ha;

   // slot width, lane bits per frame
   localparam int CLSM_W8 = 8;
   localparam int CLSM_W10 = 10;
   localparam int CLSM_W12 = 12;
   localparam int CLSM_LB8 = 8;
   localparam int CLSM_LB16 = 16;
   localparam int CLSM_LB24 = 24;
   localparam int CLSM_LB40 = 40;

   localparam logic CLSM_RST_VALID = 1'b0;
   localparam logic CLSM_RST_READY = 1'b0;

   typedef enum logic [1:0] {
      CLSM_PART_SINGLE = 2'h0,
      CLSM_PART_DUAL = 2'h1,
      CLSM_PART_QUAD = 2'h2
   } clsm_part_e;
endpackage : clsm_pkg

`default_nettype wire

// ### rtl/clsm_mapper.sv
// converter lane sample mapper: one frame of channel samples to up to eight lane words
// assumes samples and configuration are synchronous to mclk; config is sampled with each frame
`default_nettype none

module clsm_mapper
   import clsm_pkg::*;
#(
   parameter int NUM_LANES = CLSM_LANES
) (
   // clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // configuration
   input wire logic [3:0] link_mapping_mode,
   input wire clsm_part_e part_size,
   // sample side: sample k of channel c at bits [(c*8+k)*9 +: 9]
   input wire logic smp_valid,
   output logic smp_ready,
   input wire logic [CLSM_SMP_W-1:0] smp_data,
   // lane side: lane l at bits [l*40 +: 40], octet 0 in the top byte
   output logic lane_valid,
   input wire logic lane_ready,
   output logic [CLSM_MAP_W-1:0] lane_data,
   output logic [CLSM_LANES-1:0] lane_en,
   output logic [2:0] lane_octets,
   output logic lane_enc_64b66b
);

   if (NUM_LANES != CLSM_LANES) begin : g_bad_lanes
      $error("clsm_mapper serves exactly eight lanes");
   end

   function automatic logic [8:0] pick(logic [CLSM_SMP_W-1:0] d, int ch, int k);
      return d[(ch*CLSM_SAMPLES+k)*CLSM_SAMPLE_BITS +: CLSM_SAMPLE_BITS];
   endfunction

   // slots are laid end to end across lanes, or interleaved on lane pairs
   function automatic logic [CLSM_MAP_W-1:0] gen_map(int w, int spc, int lb, logic il, int nch,
                                                    logic [CLSM_SMP_W-1:0] d);
      logic [CLSM_MAP_W-1:0] r;
      logic [8:0] s;
      int g;
      int p;
      int ch;
      int k;
      r = '0;
      for (int l = 0; l < CLSM_LANES; l++) begin
         for (int b = 0; b < CLSM_LANE_BITS; b++) begin
            if (b < lb) begin
               if (il) begin
                  ch = l / 2;
                  k = 2 * (b / w) + (l % 2);
                  p = b % w;
               end else begin
                  g = l * lb + b;
                  ch = (g / w) / spc;
                  k = (g / w) % spc;
                  p = g % w;
               end
               // 8-bit slots take the top eight bits; wider slots pad zeros below
               if (ch < nch && p < ((w == CLSM_W8) ? 8 : 9)) begin
                  s = pick(d, ch, k);
                  r[l*CLSM_LANE_BITS + CLSM_LANE_BITS - 1 - b] = s[8-p];
               end
            end
         end
      end
      return r;
   endfunction

   function automatic logic [CLSM_LANES-1:0] gen_en(int used);
      logic [CLSM_LANES-1:0] m;
      m = '0;
      for (int l = 0; l < CLSM_LANES; l++) begin
         m[l] = (l < used);
      end
      return m;
   endfunction

   int nch;
   logic [CLSM_MAP_W-1:0] mapped;
   logic [CLSM_LANES-1:0] map_en;
   logic [2:0] map_oct;
   logic map_enc;

   always_comb begin
      unique case (part_size)
         CLSM_PART_QUAD: nch = 4;
         CLSM_PART_DUAL: nch = 2;
         default: nch = 1;
      endcase
   end

   always_comb begin
      mapped = '0;
      map_en = '0;
      map_oct = 3'h0;
      map_enc = 1'b0;
      unique case (link_mapping_mode)
         CLSM_MODE_4: begin
            mapped = gen_map(CLSM_W12, 1, CLSM_LB16, 1'b0, nch, smp_data);
            map_en = gen_en((nch * CLSM_W12 + CLSM_LB16 - 1) / CLSM_LB16);
            map_oct = 3'h2;
            map_enc = 1'b1;
         end
         CLSM_MODE_5: begin
            mapped = gen_map(CLSM_W8, 1, CLSM_LB16, 1'b0, nch, smp_data);
            map_en = gen_en((nch * CLSM_W8 + CLSM_LB16 - 1) / CLSM_LB16);
            map_oct = 3'h2;
            map_enc = 1'b1;
         end
         CLSM_MODE_6: begin
            mapped = gen_map(CLSM_W12, 2, CLSM_LB16, 1'b0, nch, smp_data);
            map_en = gen_en((nch * 2 * CLSM_W12 + CLSM_LB16 - 1) / CLSM_LB16);
            map_oct = 3'h2;
            map_enc = 1'b1;
         end
         CLSM_MODE_7: begin
            mapped = gen_map(CLSM_W8, 1, CLSM_LB8, 1'b0, nch, smp_data);
            map_en = gen_en(nch);
            map_oct = 3'h1;
            map_enc = 1'b1;
         end
         CLSM_MODE_8: begin
            mapped = gen_map(CLSM_W12, 2, CLSM_LB24, 1'b0, nch, smp_data);
            map_en = gen_en(nch);
            map_oct = 3'h3;
            map_enc = 1'b1;
         end
         CLSM_MODE_9: begin
            mapped = gen_map(CLSM_W8, 2, CLSM_LB8, 1'b0, nch, smp_data);
            map_en = gen_en(2 * nch);
            map_oct = 3'h1;
         end
         CLSM_MODE_10: begin
            mapped = gen_map(CLSM_W10, 8, CLSM_LB40, 1'b1, nch, smp_data);
            map_en = gen_en(2 * nch);
            map_oct = 3'h5;
         end
         default: begin
            // modes outside 4..10 send an empty frame with no lane enabled
            mapped = '0;
         end
      endcase
   end

   // two-entry buffer: head drives the lane ports, spare catches a frame during a stall
   logic [CLSM_REC_W-1:0] head_ff, nxt_head;
   logic [CLSM_REC_W-1:0] spare_ff, nxt_spare;
   logic head_v_ff, nxt_head_v;
   logic spare_v_ff, nxt_spare_v;
   logic rdy_ff, nxt_rdy;
   logic push;
   logic pop;
   logic [CLSM_REC_W-1:0] rec;

   always_comb begin
      rec = {map_enc, map_oct, map_en, mapped};
      push = smp_valid && rdy_ff;
      pop = head_v_ff && lane_ready;
      nxt_head = head_ff;
      nxt_head_v = head_v_ff;
      nxt_spare = spare_ff;
      nxt_spare_v = spare_v_ff;
      if (!head_v_ff || pop) begin
         if (spare_v_ff) begin
            nxt_head = spare_ff;
            nxt_head_v = 1'b1;
            nxt_spare_v = push;
            nxt_spare = rec;
         end else begin
            nxt_head_v = push;
            nxt_head = rec;
         end
      end else if (push) begin
         nxt_spare = rec;
         nxt_spare_v = 1'b1;
      end
      // ready falls as soon as the spare is taken, so no frame is ever dropped
      nxt_rdy = !nxt_spare_v;
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         head_ff <= '0;
         spare_ff <= '0;
         head_v_ff <= CLSM_RST_VALID;
         spare_v_ff <= CLSM_RST_VALID;
         rdy_ff <= CLSM_RST_READY;
      end else begin
         head_ff <= nxt_head;
         spare_ff <= nxt_spare;
         head_v_ff <= nxt_head_v;
         spare_v_ff <= nxt_spare_v;
         rdy_ff <= nxt_rdy;
      end
   end

   assign smp_ready = rdy_ff;
   assign lane_valid = head_v_ff;
   assign lane_data = head_ff[CLSM_MAP_W-1:0];
   assign lane_en = head_ff[CLSM_MAP_W +: CLSM_LANES];
   assign lane_octets = head_ff[CLSM_MAP_W+CLSM_LANES +: 3];
   assign lane_enc_64b66b = head_ff[CLSM_REC_W-1];

   // a function result cannot be sliced, so partial samples are read straight from smp_data
   a_mode4_straddle: assert property (@(posedge mclk) disable iff (!rstn)
      (link_mapping_mode == CLSM_MODE_4 && part_size == CLSM_PART_QUAD) |->
      (mapped[39:24] == {pick(smp_data, 0, 0), 3'h0, smp_data[80:77]} && map_en == 8'h07))
      else $error("mode 4 slot straddle wrong");
   a_mode5_fill: assert property (@(posedge mclk) disable iff (!rstn)
      (link_mapping_mode == CLSM_MODE_5 && part_size == CLSM_PART_SINGLE) |->
      (mapped[39:24] == {smp_data[8:1], 8'h00} && map_en == 8'h01))
      else $error("mode 5 single fill wrong");
   a_mode6_split: assert property (@(posedge mclk) disable iff (!rstn)
      (link_mapping_mode == CLSM_MODE_6 && part_size == CLSM_PART_QUAD) |->
      (mapped[79:64] == {smp_data[13:9], 3'h0, smp_data[80:73]}))
      else $error("mode 6 nibble split wrong");
   a_mode7_lanes: assert property (@(posedge mclk) disable iff (!rstn)
      (link_mapping_mode == CLSM_MODE_7 && part_size == CLSM_PART_QUAD) |->
      (mapped[159:152] == smp_data[224:217] && map_oct == 3'h1))
      else $error("mode 7 lane D wrong");
   a_mode8_pair: assert property (@(posedge mclk) disable iff (!rstn)
      (link_mapping_mode == CLSM_MODE_8 && part_size == CLSM_PART_QUAD) |->
      (mapped[119:96] == {pick(smp_data, 2, 0), 3'h0, pick(smp_data, 2, 1), 3'h0}))
      else $error("mode 8 sample pair wrong");
   a_mode9_pair: assert property (@(posedge mclk) disable iff (!rstn)
      (link_mapping_mode == CLSM_MODE_9 && part_size == CLSM_PART_DUAL) |->
      (mapped[79:72] == smp_data[17:10] && map_en == 8'h0f && !map_enc))
      else $error("mode 9 lane pair wrong");
   a_mode10_odd: assert property (@(posedge mclk) disable iff (!rstn)
      (link_mapping_mode == CLSM_MODE_10 && part_size == CLSM_PART_QUAD) |->
      (mapped[69:60] == {pick(smp_data, 0, 3), 1'b0} && map_oct == 3'h5))
      else $error("mode 10 odd sample wrong");
   a_unused_lanes: assert property (@(posedge mclk) disable iff (!rstn)
      // only a frame that goes straight to the head shows next cycle; a stalled head is older
      (push && part_size == CLSM_PART_DUAL && !spare_v_ff && (!head_v_ff || pop)) |=>
      (lane_data[319:160] == '0 && lane_en[7:4] == 4'h0))
      else $error("lane beyond part carries data");
   a_stall_hold: assert property (@(posedge mclk) disable iff (!rstn)
      (lane_valid && !lane_ready) |=> (lane_valid && $stable(lane_data) && $stable(lane_en)))
      else $error("lane frame changed during stall");

endmodule : clsm_mapper

`default_nettype wire

// ### verif/clsm_rx_model.sv
// lane-side receiver model: takes lane frames, prompt, slow or stalled on request
// assumes mclk and rstn are shared with the mapper
`default_nettype none

module clsm_rx_model (
   // clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // bench control
   input wire logic hold,
   input wire logic slow,
   // lane handshake
   input wire logic lane_valid,
   output logic lane_ready
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] cnt_ff;
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) cnt_ff <= 2'h0;
      else if (lane_valid) cnt_ff <= cnt_ff + 2'h1;
   end
   // slow receiver raises ready only when cnt_ff reaches three, so an offered frame waits up to three cycles and frames pile up in the buffer
   assign lane_ready = rstn && !hold && (!slow || cnt_ff == 2'h3);
endmodule // clsm_rx_model

`default_nettype wire

// ### verif/clsm_mapper_tb.sv
// bench for the lane sample mapper: frames of every link mode and part size
// assumes clsm_rx_model as the lane-side receiver
`default_nettype none

module clsm_mapper_tb
   import clsm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk = 1'b0;
   logic rstn = 1'b0;
   logic [3:0] mode = 4'h4;
   clsm_part_e part = CLSM_PART_QUAD;
   clsm_part_e cp;
   logic smp_valid = 1'b0;
   logic [CLSM_SMP_W-1:0] smp_data = '0;
   logic [CLSM_SMP_W-1:0] d;
   logic hold = 1'b0;
   logic slow = 1'b0;
   logic smp_ready, lane_valid, lane_ready, lane_enc_64b66b;
   logic [CLSM_MAP_W-1:0] lane_data, ex;
   logic [CLSM_LANES-1:0] lane_en;
   logic [2:0] lane_octets;
   logic [CLSM_MAP_W+11:0] expq[$];
   int n_mismatch = 0;
   int tests_run = 0;
   always #50 mclk = ~mclk;
   clsm_mapper #(.NUM_LANES(8)) i_clsm_mapper (.mclk(mclk), .rstn(rstn), .link_mapping_mode(mode),
      .part_size(part), .smp_valid(smp_valid), .smp_ready(smp_ready), .smp_data(smp_data),
      .lane_valid(lane_valid), .lane_ready(lane_ready), .lane_data(lane_data), .lane_en(lane_en),
      .lane_octets(lane_octets), .lane_enc_64b66b(lane_enc_64b66b));
   clsm_rx_model i_clsm_rx_model (.mclk(mclk), .rstn(rstn), .hold(hold), .slow(slow),
      .lane_valid(lane_valid), .lane_ready(lane_ready));

   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input bit ok, input string msg);
      tests_run++;
      if (!ok) begin
         n_mismatch++;
         $display("BAD %0t %s", $time, msg);
      end
   endtask
   function automatic int nch();
      return (cp == CLSM_PART_QUAD) ? 4 : (cp == CLSM_PART_DUAL) ? 2 : 1;
   endfunction
   // channels beyond the part read as zero
   function automatic logic [8:0] s(int c, int k);
      return (c < nch()) ? d[(c*8+k)*9 +: 9] : 9'h0;
   endfunction
   function automatic void put(int l, int p, logic [11:0] v, int w);
      for (int i = 0; i < w; i++) ex[l*40+39-p-i] = v[w-1-i];
   endfunction
   // stream modes run end to end over 16-bit lanes
   function automatic void puts(int p, logic [11:0] v, int w);
      for (int i = 0; i < w; i++) put((p+i)/16, (p+i)%16, v >> (w-1-i), 1);
   endfunction

   // entered at a rising edge; returns at the edge that takes the frame
   task automatic send(input logic [3:0] m, input clsm_part_e pt, input int sd, input bit last);
      int n, nl;
      logic [2:0] oc;
      for (int i = 0; i < 32; i++) d[i*9 +: 9] = 9'(i * 37 + sd * 11 + 5);
      cp = pt;
      ex = '0;
      n = nch();
      nl = 0;
      oc = 3'h0;
      for (int c = 0; c < 4; c++) begin
         for (int k = 0; k < 2; k++) begin
            case (m)
               CLSM_MODE_4: if (k == 0) puts(c*12, {s(c,0), 3'h0}, 12);
               CLSM_MODE_5: if (k == 0) puts(c*8, s(c,0) >> 1, 8);
               CLSM_MODE_6: puts((c*2+k)*12, {s(c,k), 3'h0}, 12);
               CLSM_MODE_7: if (k == 0) put(c, 0, s(c,0) >> 1, 8);
               CLSM_MODE_8: put(c, k*12, {s(c,k), 3'h0}, 12);
               CLSM_MODE_9: put(2*c+k, 0, s(c,k) >> 1, 8);
               CLSM_MODE_10: for (int q = 0; q < 4; q++) put(2*c+k, q*10, {s(c,k+2*q), 1'b0}, 10);
               default: ;
            endcase
         end
      end
      case (m)
         CLSM_MODE_4: nl = (n == 4) ? 3 : n;
         CLSM_MODE_5: nl = (n == 4) ? 2 : 1;
         CLSM_MODE_6: nl = (n == 4) ? 6 : n + 1;
         CLSM_MODE_7, CLSM_MODE_8: nl = n;
         CLSM_MODE_9, CLSM_MODE_10: nl = 2 * n;
         default: ;
      endcase
      case (m)
         CLSM_MODE_4, CLSM_MODE_5, CLSM_MODE_6: oc = 3'h2;
         CLSM_MODE_7, CLSM_MODE_9: oc = 3'h1;
         CLSM_MODE_8: oc = 3'h3;
         CLSM_MODE_10: oc = 3'h5;
         default: ;
      endcase
      expq.push_back({8'((1 << nl) - 1), oc, (m >= CLSM_MODE_4 && m <= CLSM_MODE_8), ex});
      smp_data <= d;
      mode <= m;
      part <= pt;
      smp_valid <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(negedge mclk);
         if (smp_ready === 1'b1) break;
      end
      if (n == 50) begin
         n_mismatch++;
         wrap_up();
      end
      @(posedge mclk);
      if (last) smp_valid <= 1'b0;
   endtask
   task automatic recv;
      logic [CLSM_MAP_W+11:0] e;
      int i;
      e = expq.pop_front();
      for (i = 0; i < 200; i++) begin
         @(negedge mclk);
         if (lane_valid === 1'b1 && lane_ready === 1'b1) break;
      end
      if (i == 200) begin
         n_mismatch++;
         wrap_up();
      end
      chk({lane_en, lane_octets, lane_enc_64b66b, lane_data} === e, "lane frame differs");
      // return at the edge that takes the frame, so the next stimulus starts on a rising edge
      @(posedge mclk);
   endtask

   task automatic t_reset;
      repeat (19) @(posedge mclk);
      @(negedge mclk);
      chk({smp_ready, lane_valid, lane_en, lane_octets, lane_enc_64b66b, lane_data} === '0, "outputs not clear in reset");
      @(posedge mclk);
      rstn <= 1'b1;
      @(posedge mclk);
      @(negedge mclk);
      chk(smp_ready === 1'b1, "not ready after reset");
      @(posedge mclk);
   endtask
   // every mode plus out-of-range modes 3 and 11, on every part size; odd parts meet a slow receiver
   task automatic t_modes;
      for (int p = 0; p < 4; p++) begin
         slow <= p[0];
         for (int m = 3; m < 12; m++) begin
            send(4'(m), clsm_part_e'(p), m + 9 * p, 1'b1);
            recv();
         end
      end
      slow <= 1'b0;
   endtask
   // two frames back to back into a stalled receiver fill the buffer and leave in order
   task automatic t_stall;
      hold <= 1'b1;
      send(CLSM_MODE_10, CLSM_PART_QUAD, 3, 1'b0);
      send(CLSM_MODE_8, CLSM_PART_DUAL, 4, 1'b1);
      repeat (3) @(negedge mclk);
      chk(smp_ready === 1'b0 && lane_valid === 1'b1, "buffer full not shown");
      @(posedge mclk);
      hold <= 1'b0;
      recv();
      recv();
      @(negedge mclk);
      chk(smp_ready === 1'b1, "not ready after drain");
      @(posedge mclk);
   endtask

   initial begin
      t_reset();
      t_modes();
      t_stall();
      wrap_up();
   end
endmodule // clsm_mapper_tb

`default_nettype wire
